//--- verilog/sfpe_pkg.sv
// constants and types for the serial flash program/erase sequencer
// assumes a 25 MHz system clock that samples the serial pins directly
package sfpe_pkg;
    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] OP_PAGE_PGM       = 8'h02;
    localparam logic [7:0] OP_PAGE_PGM_A32   = 8'h12;
    localparam logic [7:0] OP_QUAD_PGM       = 8'h32;
    localparam logic [7:0] OP_QUAD_PGM_A32   = 8'h34;
    localparam logic [7:0] OP_SECTOR_ERS     = 8'h20;
    localparam logic [7:0] OP_SECTOR_ERS_A32 = 8'h21;
    localparam logic [7:0] OP_HALF_ERS       = 8'h52;
    localparam logic [7:0] OP_HALF_ERS_A32   = 8'h53;
    localparam logic [7:0] OP_BLOCK_ERS      = 8'hD8;
    localparam logic [7:0] OP_BLOCK_ERS_A32  = 8'hDC;

    // ----------------------------------------
    // status layout and sizes
    // ----------------------------------------
    localparam int          SR1_BUSY_BIT = 0;
    localparam int          SR1_WRL_BIT  = 1;
    localparam logic [7:0]  SR1_RESET    = 8'h00;
    localparam int          PAGE_BYTES   = 256;
    localparam int          BLK_SECTORS  = 16;
    localparam logic [15:0] HALF_LO_MASK = 16'h00FF;
    localparam logic [15:0] HALF_HI_MASK = 16'hFF00;
    localparam logic [15:0] FULL_MASK    = 16'hFFFF;
    localparam int          CNT_W        = 10;
    localparam int          WAIT_W       = 24;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_PGM_NS      = 100000;
    localparam int T_PRE_NS      = 100000;
    localparam int T_ERS_NS      = 1000000;
    localparam int PGM_CYC = (T_PGM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRE_CYC = (T_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERS_CYC = (T_ERS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {ARR_PGM, ARR_PRE, ARR_ERS} sfpe_arr_kind_t;

    typedef struct packed {
        logic           valid;
        sfpe_arr_kind_t kind;
        logic [31:0]    addr;
        logic [7:0]     data;
    } sfpe_arr_t;

    typedef struct packed {
        logic       quadEnable;
        logic       addrLen32;
        logic       fourLineMode;
    } sfpe_cfg_t;
endpackage : sfpe_pkg

//--- verilog/sfpe_shift_rx.sv
// serial byte assembler: one or four bits per serial clock rise
// assumes pins are synchronous to mclk and width changes only on byte edges
`timescale 1ns/1ps
module sfpe_shift_rx (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       csN,
    input  wire logic       sclkRise,
    input  wire logic [3:0] ioIn,
    input  wire logic       wide,
    output logic            byteValid_ff,
    output logic [7:0]      byteData_ff,
    output logic [2:0]      bitCnt_ff
);
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic [2:0] nxt_bitCnt;

    // ----------------------------------------
    // shifting
    // ----------------------------------------
    always_comb begin
        if (wide) begin
            nxt_shift  = {shift_ff[3:0], ioIn};
            nxt_bitCnt = bitCnt_ff + 3'h4;
        end else begin
            nxt_shift  = {shift_ff[6:0], ioIn[0]};
            nxt_bitCnt = bitCnt_ff + 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || csN) begin
            shift_ff     <= 8'h00;
            bitCnt_ff    <= 3'h0;
            byteValid_ff <= 1'b0;
            byteData_ff  <= 8'h00;
        end else begin
            byteValid_ff <= sclkRise && (nxt_bitCnt == 3'h0);
            if (sclkRise) begin
                shift_ff  <= nxt_shift;
                bitCnt_ff <= nxt_bitCnt;
                if (nxt_bitCnt == 3'h0) begin
                    byteData_ff <= nxt_shift;
                end
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_nibbleStep;
        @(posedge mclk) disable iff (rst)
        (sclkRise && wide && !csN) |=> (bitCnt_ff == $past(bitCnt_ff) + 3'h4);
    endproperty
    a_nibbleStep: assert property (p_nibbleStep) else $error("quad step not 4 bits");
endmodule : sfpe_shift_rx

//--- verilog/sfpe_sequencer.sv
// program/erase command decoder and sequencer of the serial flash
// assumes pins are synchronous to mclk, and an array that acts on each
// arrCmd pulse; protSectors answers combinationally for protBlock
`timescale 1ns/1ps
module sfpe_sequencer #(
    parameter int PGM_CYCLES = sfpe_pkg::PGM_CYC,
    parameter int PRE_CYCLES = sfpe_pkg::PRE_CYC,
    parameter int ERS_CYCLES = sfpe_pkg::ERS_CYC
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              sclkIn,
    input  wire logic              csN,
    input  wire logic [3:0]        ioIn,
    input  wire sfpe_pkg::sfpe_cfg_t cfg,
    input  wire logic              clrEraseError,
    input  wire logic [15:0]       protSectors,
    output logic [15:0]            protBlock,
    output logic [7:0]             statusRegOne,
    output logic                   eraseError_ff,
    output sfpe_pkg::sfpe_arr_t    arrCmd_ff
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_PROG, ST_PGWAIT, ST_PRE, ST_PREWAIT, ST_ERS, ST_ERWAIT
    } sfpe_state_t;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic [2:0] addrBytes(input logic [7:0] op, input logic a32);
        if (op == sfpe_pkg::OP_PAGE_PGM_A32 || op == sfpe_pkg::OP_QUAD_PGM_A32 ||
            op == sfpe_pkg::OP_SECTOR_ERS_A32 || op == sfpe_pkg::OP_HALF_ERS_A32 ||
            op == sfpe_pkg::OP_BLOCK_ERS_A32 || a32) begin
            return 3'h4;
        end
        return 3'h3;
    endfunction : addrBytes

    function automatic logic isQuad(input logic [7:0] op);
        return op == sfpe_pkg::OP_QUAD_PGM || op == sfpe_pkg::OP_QUAD_PGM_A32;
    endfunction : isQuad

    function automatic logic isProgram(input logic [7:0] op);
        return isQuad(op) || op == sfpe_pkg::OP_PAGE_PGM ||
               op == sfpe_pkg::OP_PAGE_PGM_A32;
    endfunction : isProgram

    function automatic logic [15:0] eraseMask(input logic [7:0] op, input logic [3:0] sec);
        if (op == sfpe_pkg::OP_SECTOR_ERS || op == sfpe_pkg::OP_SECTOR_ERS_A32) begin
            return 16'h0001 << sec;
        end
        if (op == sfpe_pkg::OP_HALF_ERS || op == sfpe_pkg::OP_HALF_ERS_A32) begin
            return sec[3] ? sfpe_pkg::HALF_HI_MASK : sfpe_pkg::HALF_LO_MASK;
        end
        if (op == sfpe_pkg::OP_BLOCK_ERS || op == sfpe_pkg::OP_BLOCK_ERS_A32) begin
            return sfpe_pkg::FULL_MASK;
        end
        return 16'h0000;
    endfunction : eraseMask

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic                          sclkPrev_ff;
    logic                          csPrev_ff;
    logic                          sclkRise;
    logic                          csRise;
    logic                          wide;
    logic                          rxValid;
    logic [7:0]                    rxByte;
    logic [2:0]                    rxBitCnt;
    logic [sfpe_pkg::CNT_W-1:0]    byteCnt_ff;
    logic [7:0]                    opcode_ff;
    logic [31:0]                   addr_ff;
    logic [7:0]                    bufIdx_ff;
    logic [7:0]                    pageBuf_ff [sfpe_pkg::PAGE_BYTES];
    logic [sfpe_pkg::PAGE_BYTES-1:0] loaded_ff;
    logic [2:0]                    aBytes;
    logic [sfpe_pkg::CNT_W-1:0]    addrEnd;
    logic                          inData;
    logic                          idle;
    logic                          framed;
    logic                          cmdWren;
    logic                          pgmOk;
    logic                          ersOk;
    logic [15:0]                   reqMask;
    logic                          protHit;
    logic                          accept;
    logic                          startPgm;
    logic                          startErs;
    logic                          protFail;
    logic                          reject;
    logic                          opDone;
    logic                          wrLatch_ff;
    logic                          busy_ff;
    sfpe_state_t                   state_ff;
    logic [sfpe_pkg::WAIT_W-1:0]   waitCnt_ff;
    logic [7:0]                    stepIdx_ff;
    logic [15:0]                   reqMask_ff;

    // ----------------------------------------
    // pin sampling and byte assembly
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclkPrev_ff <= 1'b0;
            csPrev_ff   <= 1'b1;
        end else begin
            sclkPrev_ff <= sclkIn;
            csPrev_ff   <= csN;
        end
    end

    assign sclkRise = sclkIn && !sclkPrev_ff && !csN;
    assign csRise   = csN && !csPrev_ff;
    assign aBytes   = addrBytes(opcode_ff, cfg.addrLen32);
    assign addrEnd  = {7'h00, aBytes} + 10'h001;
    assign inData   = byteCnt_ff >= addrEnd;
    // whole frame on four lines in four-line mode; quad program data otherwise
    assign wide = cfg.fourLineMode ||
                  (isQuad(opcode_ff) && inData);

    sfpe_shift_rx u_sfpe_shift_rx (
        .mclk         (mclk),
        .rst          (rst),
        .csN          (csN),
        .sclkRise     (sclkRise),
        .ioIn         (ioIn),
        .wide         (wide),
        .byteValid_ff (rxValid),
        .byteData_ff  (rxByte),
        .bitCnt_ff    (rxBitCnt)
    );

    // ----------------------------------------
    // opcode, address and page buffer
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            byteCnt_ff <= 10'h000;
            opcode_ff  <= 8'h00;
            addr_ff    <= 32'h00000000;
            bufIdx_ff  <= 8'h00;
        end else if (csN) begin
            byteCnt_ff <= 10'h000;
        end else if (rxValid) begin
            // saturate so an overlong frame never looks like a short one
            if (byteCnt_ff != 10'h3FF) begin
                byteCnt_ff <= byteCnt_ff + 10'h001;
            end
            if (byteCnt_ff == 10'h000) begin
                opcode_ff <= rxByte;
                addr_ff   <= 32'h00000000;
            end else if (!inData) begin
                addr_ff <= {addr_ff[23:0], rxByte};
                if (byteCnt_ff == {7'h00, aBytes}) begin
                    bufIdx_ff <= rxByte;
                end
            end else begin
                bufIdx_ff <= bufIdx_ff + 8'h01;
            end
        end
    end

    // buffer is frozen while an operation reads it
    always_ff @(posedge mclk) begin
        if (rst) begin
            loaded_ff <= '0;
        end else if (rxValid && byteCnt_ff == 10'h000 && idle) begin
            loaded_ff <= '0;
        end else if (rxValid && inData && isProgram(opcode_ff) && idle) begin
            loaded_ff[bufIdx_ff] <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rxValid && inData && isProgram(opcode_ff) && idle) begin
            pageBuf_ff[bufIdx_ff] <= rxByte;
        end
    end

    // ----------------------------------------
    // command acceptance on select rise
    // ----------------------------------------
    assign idle      = state_ff == ST_IDLE;
    assign framed    = rxBitCnt == 3'h0;
    assign cmdWren   = opcode_ff == sfpe_pkg::OP_WRITE_ENABLE &&
                       byteCnt_ff == 10'h001 && framed;
    assign pgmOk     = isProgram(opcode_ff) && framed && byteCnt_ff > addrEnd &&
                       (!isQuad(opcode_ff) || cfg.quadEnable);
    assign reqMask   = eraseMask(opcode_ff, addr_ff[15:12]);
    assign ersOk     = reqMask != 16'h0000 && framed && byteCnt_ff == addrEnd;
    assign protBlock = addr_ff[31:16];
    assign protHit   = (protSectors & reqMask) != 16'h0000;
    assign accept    = csRise && idle && wrLatch_ff;
    assign startPgm  = accept && pgmOk;
    assign startErs  = accept && ersOk && !protHit;
    assign protFail  = accept && ersOk && protHit;
    assign reject    = csRise && idle && byteCnt_ff != 10'h000 &&
                       (isProgram(opcode_ff) || reqMask != 16'h0000) &&
                       !startPgm && !startErs;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrLatch_ff <= 1'b0;
        end else if (csRise && idle && cmdWren) begin
            wrLatch_ff <= 1'b1;
        end else if (reject || opDone) begin
            wrLatch_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            eraseError_ff <= 1'b0;
        end else if (protFail) begin
            eraseError_ff <= 1'b1;
        end else if (clrEraseError) begin
            eraseError_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_ff <= 1'b0;
        end else if (startPgm || startErs) begin
            busy_ff <= 1'b1;
        end else if (opDone) begin
            busy_ff <= 1'b0;
        end
    end

    always_comb begin
        statusRegOne = sfpe_pkg::SR1_RESET;
        statusRegOne[sfpe_pkg::SR1_BUSY_BIT] = busy_ff;
        statusRegOne[sfpe_pkg::SR1_WRL_BIT]  = wrLatch_ff;
    end

    // ----------------------------------------
    // array sequencing
    // ----------------------------------------
    assign opDone = (state_ff == ST_PGWAIT || state_ff == ST_ERWAIT) &&
                    waitCnt_ff == '0;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff   <= ST_IDLE;
            waitCnt_ff <= '0;
            stepIdx_ff <= 8'h00;
            reqMask_ff <= 16'h0000;
            arrCmd_ff  <= '0;
        end else begin
            arrCmd_ff.valid <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    stepIdx_ff <= 8'h00;
                    if (startPgm) begin
                        state_ff <= ST_PROG;
                    end else if (startErs) begin
                        state_ff   <= ST_PRE;
                        reqMask_ff <= reqMask;
                    end
                end
                ST_PROG: begin
                    // only loaded bytes are written, so a partial page is legal
                    arrCmd_ff.valid <= loaded_ff[stepIdx_ff];
                    arrCmd_ff.kind  <= sfpe_pkg::ARR_PGM;
                    arrCmd_ff.addr  <= {addr_ff[31:8], stepIdx_ff};
                    arrCmd_ff.data  <= pageBuf_ff[stepIdx_ff];
                    stepIdx_ff      <= stepIdx_ff + 8'h01;
                    if (stepIdx_ff == 8'hFF) begin
                        state_ff   <= ST_PGWAIT;
                        waitCnt_ff <= sfpe_pkg::WAIT_W'(PGM_CYCLES - 1);
                    end
                end
                ST_PRE, ST_ERS: begin
                    arrCmd_ff.valid <= reqMask_ff[stepIdx_ff[3:0]];
                    arrCmd_ff.kind  <= state_ff == ST_PRE ? sfpe_pkg::ARR_PRE
                                                          : sfpe_pkg::ARR_ERS;
                    arrCmd_ff.addr  <= {addr_ff[31:16], stepIdx_ff[3:0], 12'h000};
                    arrCmd_ff.data  <= 8'hFF;
                    stepIdx_ff      <= stepIdx_ff + 8'h01;
                    if (stepIdx_ff[3:0] == 4'hF) begin
                        state_ff   <= state_ff == ST_PRE ? ST_PREWAIT : ST_ERWAIT;
                        waitCnt_ff <= state_ff == ST_PRE
                                    ? sfpe_pkg::WAIT_W'(PRE_CYCLES - 1)
                                    : sfpe_pkg::WAIT_W'(ERS_CYCLES - 1);
                    end
                end
                ST_PREWAIT: begin
                    stepIdx_ff <= 8'h00;
                    if (waitCnt_ff == '0) begin
                        state_ff <= ST_ERS;
                    end else begin
                        waitCnt_ff <= waitCnt_ff - 1'b1;
                    end
                end
                ST_PGWAIT, ST_ERWAIT: begin
                    if (waitCnt_ff == '0) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        waitCnt_ff <= waitCnt_ff - 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_needLatch;
        @(posedge mclk) disable iff (rst)
        (startPgm || startErs) |-> wrLatch_ff && $past(csN) == 1'b0;
    endproperty
    a_needLatch: assert property (p_needLatch) else $error("op without latch");

    property p_quadNeedsQe;
        @(posedge mclk) disable iff (rst)
        (startPgm && isQuad(opcode_ff)) |-> cfg.quadEnable;
    endproperty
    a_quadNeedsQe: assert property (p_quadNeedsQe) else $error("quad without enable");

    property p_eraseLength;
        @(posedge mclk) disable iff (rst)
        startErs |-> rxBitCnt == 3'h0 && byteCnt_ff ==
            ((cfg.addrLen32 || opcode_ff inside {8'h21, 8'h53, 8'hDC}) ? 10'h005 : 10'h004);
    endproperty
    a_eraseLength: assert property (p_eraseLength) else $error("erase length wrong");

    property p_eraseStarts;
        @(posedge mclk) disable iff (rst)
        startErs |=> busy_ff && statusRegOne[0] && state_ff == ST_PRE;
    endproperty
    a_eraseStarts: assert property (p_eraseStarts) else $error("erase did not start");

    property p_protError;
        @(posedge mclk) disable iff (rst)
        protFail |=> eraseError_ff && !busy_ff && !wrLatch_ff;
    endproperty
    a_protError: assert property (p_protError) else $error("protected erase ran");

    property p_latchDrop;
        @(posedge mclk) disable iff (rst)
        $fell(busy_ff) |-> !wrLatch_ff;
    endproperty
    a_latchDrop: assert property (p_latchDrop) else $error("latch kept after op");

    property p_halfMask;
        @(posedge mclk) disable iff (rst)
        (startErs && opcode_ff inside {8'h52, 8'h53}) |=>
            reqMask_ff == ($past(addr_ff[15]) ? 16'hFF00 : 16'h00FF);
    endproperty
    a_halfMask: assert property (p_halfMask) else $error("half block mask wrong");

    property p_progRuns;
        @(posedge mclk) disable iff (rst)
        startPgm |=> (state_ff == ST_PROG)[*8];
    endproperty
    a_progRuns: assert property (p_progRuns) else $error("program not run");

    property p_preFirst;
        @(posedge mclk) disable iff (rst)
        $rose(state_ff == ST_ERS) |-> $past(state_ff) == ST_PREWAIT;
    endproperty
    a_preFirst: assert property (p_preFirst) else $error("erase without preprogram");

    property p_quadPgm;
        @(posedge mclk) disable iff (rst)
        startPgm && isQuad(opcode_ff);
    endproperty
    c_quadPgm: cover property (p_quadPgm);

    property p_halfErs;
        @(posedge mclk) disable iff (rst)
        startErs && opcode_ff == sfpe_pkg::OP_HALF_ERS;
    endproperty
    c_halfErs: cover property (p_halfErs);

    property p_protHit;
        @(posedge mclk) disable iff (rst)
        protFail;
    endproperty
    c_protHit: cover property (p_protHit);
endmodule : sfpe_sequencer

//--- tb/sfpe_host_model.sv
// host serial driver model: clocks bits or nibbles into the sequencer
// assumes one mclk domain; the bench calls its tasks by hierarchy
`timescale 1ns/1ps
module sfpe_host_model (
    input  wire logic  mclk,
    output logic       sclkIn,
    output logic       csN,
    output logic [3:0] ioIn
);
    initial begin
        sclkIn = 1'b0;
        csN    = 1'b1;
        ioIn   = 4'h0;
    end
    // data changes while the serial clock is low, msb first
    // serial clock is mclk/2, far below the quad program limit
    task automatic shift(input logic [7:0] b, input logic wide);
        for (int i = 7; i >= 0; i -= (wide ? 4 : 1)) begin
            @(posedge mclk);
            csN    <= 1'b0;
            sclkIn <= 1'b0;
            ioIn   <= wide ? b[i-:4] : {3'h0, b[i]};
            @(posedge mclk);
            sclkIn <= 1'b1;
        end
    endtask : shift
    // select rises right after the last bit; released lines toggle so no stale value
    task automatic stop();
        @(posedge mclk);
        sclkIn <= 1'b0;
        @(posedge mclk);
        csN  <= 1'b1;
        ioIn <= ~ioIn;
    endtask : stop
endmodule : sfpe_host_model

//--- tb/test_sfpe_sequencer.sv
// self-checking bench for sfpe_sequencer with shortened array timings
// assumes the host model drives the pins and this bench plays the array side
`timescale 1ns/1ps
module test_sfpe_sequencer;
    logic                mclk = 1'b0, rst = 1'b1, clrEraseError = 1'b0;
    logic                sclkIn, csN, eraseError_ff;
    logic [3:0]          ioIn;
    sfpe_pkg::sfpe_cfg_t cfg = '0;
    logic [15:0]         protSectors = 16'h0000, protBlock;
    logic [7:0]          statusRegOne, lastData;
    sfpe_pkg::sfpe_arr_t arrCmd_ff;
    logic [31:0]         seed = 32'h00004DB3, lastAddr;
    int                  err_total = 0, comparisons = 0, nPgm = 0, nPre = 0, nErs = 0;
    logic [7:0]          ops [6] = '{8'h20, 8'h21, 8'h52, 8'h53, 8'hD8, 8'hDC};
    int                  cnt [3] = '{1, 8, 16};
    always #20 mclk = ~mclk;
    sfpe_host_model u_sfpe_host_model (.mclk(mclk), .sclkIn(sclkIn), .csN(csN), .ioIn(ioIn));
    sfpe_sequencer #(.PGM_CYCLES(4), .PRE_CYCLES(4), .ERS_CYCLES(8)) u_sfpe_sequencer (
        .mclk(mclk), .rst(rst), .sclkIn(sclkIn), .csN(csN), .ioIn(ioIn), .cfg(cfg),
        .clrEraseError(clrEraseError), .protSectors(protSectors), .protBlock(protBlock),
        .statusRegOne(statusRegOne), .eraseError_ff(eraseError_ff), .arrCmd_ff(arrCmd_ff));
    // array side: counts pulses by kind, keeps the last erase address and program byte
    always @(posedge mclk) begin
        if (arrCmd_ff.valid === 1'b1) begin
            nPgm <= nPgm + int'(arrCmd_ff.kind === sfpe_pkg::ARR_PGM);
            nPre <= nPre + int'(arrCmd_ff.kind === sfpe_pkg::ARR_PRE);
            nErs <= nErs + int'(arrCmd_ff.kind === sfpe_pkg::ARR_ERS);
            if (arrCmd_ff.kind === sfpe_pkg::ARR_ERS) lastAddr <= arrCmd_ff.addr;
            if (arrCmd_ff.kind === sfpe_pkg::ARR_PGM) lastData <= arrCmd_ff.data;
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    // optional write enable frame, then one command frame; program data on four lines
    task automatic run(input logic [7:0] op, input logic [31:0] a, input int nA,
                       input int nD, input logic latch);
        if (latch) begin
            u_sfpe_host_model.shift(sfpe_pkg::OP_WRITE_ENABLE, cfg.fourLineMode);
            u_sfpe_host_model.stop();
        end
        u_sfpe_host_model.shift(op, cfg.fourLineMode);
        for (int i = nA - 1; i >= 0; i--) u_sfpe_host_model.shift(a[8*(i%4)+:8], cfg.fourLineMode);
        for (int i = 0; i < nD; i++) u_sfpe_host_model.shift(a[31:24], 1'b1);
        u_sfpe_host_model.stop();
    endtask : run
    initial begin
        #800000;
        err_total++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        #1;
        check("statusRegOne", statusRegOne, 32'h0);
        // 0..11 every erase opcode; 12 quad off; 13 protected; 14 no latch; 15 late select;
        // 16 good quad program; 17 quad program without latch
        for (int k = 0; k < 18; k++) begin
            int j, nA, nD, p0, e0, g0, exp;
            logic [31:0] a;
            logic [7:0]  op;
            logic [3:0]  sec;
            @(posedge mclk);
            j = k % 6;
            a = rnd();
            cfg.addrLen32    <= a[0];
            cfg.fourLineMode <= a[1];
            cfg.quadEnable   <= (k != 12);
            protSectors      <= (k == 13) ? 16'hFFFF : 16'h0000;
            clrEraseError    <= (k == 14);
            @(posedge mclk);
            op = (k < 12) ? ops[j] : (k == 12 || k > 15) ? (a[2] ? 8'h34 : 8'h32) : 8'hD8;
            nA = (a[0] || op inside {8'h21, 8'h53, 8'hDC, 8'h34}) ? 4 : 3;
            nD = (op inside {8'h32, 8'h34}) ? 2 : 0;
            sec = (j < 2) ? a[15:12] : (j < 4) ? {a[15], 3'h7} : 4'hF;
            exp = (k < 12) ? cnt[j / 2] : 0;
            p0 = nPre;
            e0 = nErs;
            g0 = nPgm;
            run(op, a, nA + int'(k == 15), nD, k != 14 && k != 17);
            repeat (3) @(posedge mclk);
            #1;
            check("busy", statusRegOne[0], k < 12 || k == 16);
            for (int i = 0; i < 3000 && statusRegOne[0] !== 1'b0; i++) @(posedge mclk);
            @(posedge mclk);
            #1;
            check("preCount", nPre - p0, exp);
            check("ersCount", nErs - e0, exp);
            check("pgmCount", nPgm - g0, (k == 16) ? 2 : 0);
            check("eraseError", eraseError_ff, k == 13);
            check("busyLatch", statusRegOne[1:0], 0);
            if (k == 16) check("pgmData", lastData, a[31:24]);
            if (k < 12) begin
                check("protBlock", protBlock, {(nA == 4) ? a[31:24] : 8'h00, a[23:16]});
                check("sector", lastAddr[15:12], sec);
            end
        end
        final_report();
    end
endmodule : test_sfpe_sequencer
